// File: inc/bsp_pkg.sv
// package: constants, carriers and helper functions of the byte swap and parity unit
package bsp_pkg;

    // ==========================================================
    // register map and reset values
    localparam logic [7:0] BSP_CTRL_OFS = 8'h00;
    localparam logic [7:0] BSP_STAT_OFS = 8'h04;
    localparam int BSP_CTRL_ODD_BIT = 0;
    localparam logic BSP_ODD_RST = 1'b1;
    localparam logic [35:0] BSP_WORD_RST = 36'h0_0000_0000;
    localparam logic [31:0] BSP_RDATA_RST = 32'h0000_0000;

    // ==========================================================
    // port-b width codes, {b_width_sel_hi, b_width_sel_lo}
    typedef enum logic [1:0] {
        BSP_LONG = 2'b00,
        BSP_WORD = 2'b01,
        BSP_BYTE = 2'b10,
        BSP_MAIL = 2'b11
    } bsp_width_t;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic port_a_select_n;
        logic port_a_xfer_gate;
        logic port_a_write_not_read;
        logic port_a_mailbox_sel;
        logic port_a_parity_gen_sel;
    } bsp_a_ctl_t;

    typedef struct packed {
        logic port_b_select_n;
        logic port_b_xfer_gate;
        logic port_b_write_not_read;
        logic b_width_sel_hi;
        logic b_width_sel_lo;
        logic big_endian_sel_n;
        logic swap_sel_hi;
        logic swap_sel_lo;
        logic port_b_parity_gen_sel;
    } bsp_b_ctl_t;

    typedef struct packed {
        logic [35:0] a_dout;
        logic [35:0] b_dout;
        logic [35:0] rd_buf;
        logic [35:0] wr_buf;
        logic [35:0] a_wr_data;
        logic [35:0] b_wr_data;
        logic [1:0] rd_phase;
        logic [1:0] wr_phase;
        logic [1:0] wr_swap;
        bsp_width_t rd_width;
        bsp_width_t wr_width;
        logic rd_big;
        logic wr_big;
        logic ab_q_push;
        logic ab_mb_wr;
        logic ba_q_push;
        logic ba_mb_wr;
        logic pa_err_n;
        logic pb_err_n;
        logic parity_odd;
        logic [31:0] prdata;
    } bsp_state_t;

    localparam bsp_state_t BSP_STATE_RST = '{
        a_dout: BSP_WORD_RST, b_dout: BSP_WORD_RST, rd_buf: BSP_WORD_RST,
        wr_buf: BSP_WORD_RST, a_wr_data: BSP_WORD_RST, b_wr_data: BSP_WORD_RST,
        rd_phase: 2'h0, wr_phase: 2'h0, wr_swap: 2'h0,
        rd_width: BSP_LONG, wr_width: BSP_LONG, rd_big: 1'b0, wr_big: 1'b0,
        ab_q_push: 1'b0, ab_mb_wr: 1'b0, ba_q_push: 1'b0, ba_mb_wr: 1'b0,
        pa_err_n: 1'b1, pb_err_n: 1'b1, parity_odd: BSP_ODD_RST,
        prdata: BSP_RDATA_RST};

    // ==========================================================
    // helpers
    // whole nine-bit bytes move, bit order kept
    function automatic logic [35:0] bsp_swap(input logic [35:0] w, input logic [1:0] m);
        logic [8:0] ba, bb, bc, bd;
        ba = w[35:27];
        bb = w[26:18];
        bc = w[17:9];
        bd = w[8:0];
        unique case (m)
            2'b00: return w;
            2'b01: return {bd, bc, bb, ba};
            2'b10: return {bc, bd, ba, bb};
            default: return {bb, ba, bd, bc};
        endcase
    endfunction

    // top bit of each byte replaced by parity of its low eight
    function automatic logic [35:0] bsp_gen(input logic [35:0] w, input logic odd);
        logic [35:0] r;
        r = w;
        for (int i = 0; i < 4; i++) begin
            r[i*9+8] = odd ? ~^w[i*9+:8] : ^w[i*9+:8];
        end
        return r;
    endfunction

    // one error bit per byte tree
    function automatic logic [3:0] bsp_err(input logic [35:0] w, input logic odd);
        logic [3:0] e;
        e = 4'h0;
        for (int i = 0; i < 4; i++) begin
            e[i] = odd ? ~^w[i*9+:9] : ^w[i*9+:9];
        end
        return e;
    endfunction

    function automatic logic [1:0] bsp_last(input bsp_width_t wd);
        unique case (wd)
            BSP_WORD: return 2'h1;
            BSP_BYTE: return 2'h3;
            default: return 2'h0;
        endcase
    endfunction

endpackage

// File: rtl/bsp_unit.sv
// design: port-b byte swapping with parity checking and generation on both ports
// Function
// - four swap orders chosen by swap selects
// - mailbox data never swapped
// - whole bytes move, bit order kept
// - swap selects sampled on new long word
// - captured swap held for whole long word
// - queue reads swap first, then size
// - queue writes assemble first, then swap
// - four nine-bit parity trees per port
// - port-a error low on any byte failure
// - port-b error covers width-masked bytes; little-endian byte width checks byte 1, not data lane 0
// - word width checks upper or lower pair
// - byte width checks top or second byte
// - parity sense sets check polarity
// - port-a error held high on mailbox generation
// - port-b error held high on mailbox generation
// - generate select enables read parity generation
// - writes store all nine bits unchanged
// - generated bit replaces stored top bit
// - queue parity made before output register
// - generate selects take effect on load edge; port-b queue reads use the select of a long word's first piece
// - mailbox generation reuses trees, keeps contents
// - both width selects high pick mailboxes
// - queues hold whole long words only
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module bsp_unit
    import bsp_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // port a
    input wire bsp_a_ctl_t a_ctl,
    input wire logic [35:0] a_din,
    output logic [35:0] a_dout,
    output logic port_a_parity_err_n,
    // port b
    input wire bsp_b_ctl_t b_ctl,
    input wire logic [35:0] b_din,
    output logic [35:0] b_dout,
    output logic port_b_parity_err_n,
    // a_to_b queue and mailbox
    output logic [35:0] a_wr_data,
    output logic a_to_b_queue_push,
    output logic a_to_b_mailbox_wr,
    input wire logic [35:0] a_to_b_queue_rd_data,
    output logic a_to_b_queue_pop,
    input wire logic [35:0] a_to_b_mailbox_data,
    // b_to_a queue and mailbox
    output logic [35:0] b_wr_data,
    output logic b_to_a_queue_push,
    output logic b_to_a_mailbox_wr,
    input wire logic [35:0] b_to_a_queue_rd_data,
    output logic b_to_a_queue_pop,
    input wire logic [35:0] b_to_a_mailbox_data
);

    // refuse an address bus too narrow for the register decode
    if (ADDR_W < 8) begin : g_addr_chk
        $error("bsp_unit: ADDR_W must be at least 8");
    end

    // ==========================================================
    // lane helpers
    // place piece k of a long word on the port-b lanes; other lanes hold
    function automatic logic [35:0] place(input logic [35:0] old, input logic [35:0] w,
                                          input bsp_width_t wd, input logic big,
                                          input logic [1:0] k);
        logic [35:0] r;
        logic [1:0] idx;
        logic [17:0] half;
        r = old;
        idx = big ? 2'(2'h3 - k) : k;
        half = (big ^ k[0]) ? w[35:18] : w[17:0];
        unique case (wd)
            BSP_WORD: begin
                if (big) begin
                    r[35:18] = half;
                end else begin
                    r[17:0] = half;
                end
            end
            BSP_BYTE: begin
                if (big) begin
                    r[35:27] = w[idx*9+:9];
                end else begin
                    r[8:0] = w[idx*9+:9];
                end
            end
            default: r = w;
        endcase
        return r;
    endfunction

    // gather piece k from the port-b lanes into the long word
    function automatic logic [35:0] gather(input logic [35:0] acc, input logic [35:0] din,
                                           input bsp_width_t wd, input logic big,
                                           input logic [1:0] k);
        logic [35:0] r;
        logic [1:0] idx;
        logic [17:0] half;
        logic [8:0] lane;
        r = acc;
        idx = big ? 2'(2'h3 - k) : k;
        half = big ? din[35:18] : din[17:0];
        lane = big ? din[35:27] : din[8:0];
        unique case (wd)
            BSP_WORD: begin
                if (big ^ k[0]) begin
                    r[35:18] = half;
                end else begin
                    r[17:0] = half;
                end
            end
            BSP_BYTE: r[idx*9+:9] = lane;
            default: r = din;
        endcase
        return r;
    endfunction

    // bytes checked for the port-b width; little-endian byte width gives byte 1, not data lane 0
    function automatic logic [3:0] bmask(input bsp_width_t wd, input logic big);
        unique case (wd)
            BSP_WORD: return big ? 4'hc : 4'h3;
            BSP_BYTE: return big ? 4'h8 : 4'h2;
            default: return 4'hf;
        endcase
    endfunction

    // ==========================================================
    // state
    bsp_state_t s;
    bsp_state_t next_s;

    logic a_rd;
    logic a_wr;
    logic b_rd;
    logic b_wr;
    logic b_big;
    logic b_mail;
    logic b_new_rd;
    logic b_new_wr;
    logic a_hold;
    logic b_hold;
    logic apb_setup;
    logic apb_access;
    logic apb_mapped;
    bsp_width_t bw;
    logic [1:0] rd_k;
    logic [1:0] wr_k;
    logic [1:0] wr_swap_now;
    logic [35:0] rd_word;
    logic [35:0] wr_asm;

    always_comb begin
        next_s = s;
        next_s.ab_q_push = 1'b0;
        next_s.ab_mb_wr = 1'b0;
        next_s.ba_q_push = 1'b0;
        next_s.ba_mb_wr = 1'b0;

        a_rd = !a_ctl.port_a_select_n && a_ctl.port_a_xfer_gate
            && !a_ctl.port_a_write_not_read;
        a_wr = !a_ctl.port_a_select_n && a_ctl.port_a_xfer_gate
            && a_ctl.port_a_write_not_read;
        b_rd = !b_ctl.port_b_select_n && b_ctl.port_b_xfer_gate
            && !b_ctl.port_b_write_not_read;
        b_wr = !b_ctl.port_b_select_n && b_ctl.port_b_xfer_gate
            && b_ctl.port_b_write_not_read;
        bw = bsp_width_t'({b_ctl.b_width_sel_hi, b_ctl.b_width_sel_lo});
        b_big = !b_ctl.big_endian_sel_n;
        b_mail = (bw == BSP_MAIL);

        // ======================================================
        // port a
        if (a_rd) begin
            if (a_ctl.port_a_mailbox_sel) begin
                next_s.a_dout = a_ctl.port_a_parity_gen_sel
                    ? bsp_gen(b_to_a_mailbox_data, s.parity_odd) : b_to_a_mailbox_data;
            end else begin
                next_s.a_dout = a_ctl.port_a_parity_gen_sel
                    ? bsp_gen(b_to_a_queue_rd_data, s.parity_odd) : b_to_a_queue_rd_data;
            end
        end
        if (a_wr) begin
            next_s.a_wr_data = a_din;
            next_s.ab_mb_wr = a_ctl.port_a_mailbox_sel;
            next_s.ab_q_push = !a_ctl.port_a_mailbox_sel;
        end

        // ======================================================
        // port b reads
        b_new_rd = b_rd && !b_mail
            && (s.rd_phase == 2'h0 || bw != s.rd_width || b_big != s.rd_big);
        rd_k = b_new_rd ? 2'h0 : s.rd_phase;
        rd_word = bsp_swap(a_to_b_queue_rd_data, {b_ctl.swap_sel_hi, b_ctl.swap_sel_lo});
        if (b_ctl.port_b_parity_gen_sel) begin
            rd_word = bsp_gen(rd_word, s.parity_odd);
        end
        if (!b_new_rd) begin
            rd_word = s.rd_buf;
        end
        if (b_rd && b_mail) begin
            next_s.b_dout = b_ctl.port_b_parity_gen_sel
                ? bsp_gen(a_to_b_mailbox_data, s.parity_odd) : a_to_b_mailbox_data;
        end else if (b_rd) begin
            next_s.rd_buf = rd_word;
            next_s.b_dout = place(s.b_dout, rd_word, bw, b_big, rd_k);
            next_s.rd_phase = (rd_k == bsp_last(bw)) ? 2'h0 : 2'(rd_k + 2'h1);
            next_s.rd_width = bw;
            next_s.rd_big = b_big;
        end

        // ======================================================
        // port b writes
        b_new_wr = b_wr && !b_mail
            && (s.wr_phase == 2'h0 || bw != s.wr_width || b_big != s.wr_big);
        wr_k = b_new_wr ? 2'h0 : s.wr_phase;
        wr_swap_now = b_new_wr ? {b_ctl.swap_sel_hi, b_ctl.swap_sel_lo} : s.wr_swap;
        wr_asm = gather(s.wr_buf, b_din, bw, b_big, wr_k);
        if (b_wr && b_mail) begin
            next_s.b_wr_data = b_din;
            next_s.ba_mb_wr = 1'b1;
        end else if (b_wr) begin
            next_s.wr_buf = wr_asm;
            next_s.wr_swap = wr_swap_now;
            next_s.wr_width = bw;
            next_s.wr_big = b_big;
            if (wr_k == bsp_last(bw)) begin
                next_s.b_wr_data = bsp_swap(wr_asm, wr_swap_now);
                next_s.ba_q_push = 1'b1;
                next_s.wr_phase = 2'h0;
            end else begin
                next_s.wr_phase = 2'(wr_k + 2'h1);
            end
        end

        // ======================================================
        // parity checking, refreshed every clock
        a_hold = a_rd && a_ctl.port_a_mailbox_sel && a_ctl.port_a_parity_gen_sel;
        b_hold = b_rd && b_mail && b_ctl.port_b_parity_gen_sel;
        next_s.pa_err_n = a_hold || !(|bsp_err(a_din, s.parity_odd));
        next_s.pb_err_n = b_hold
            || !(|(bsp_err(b_din, s.parity_odd) & bmask(bw, b_big)));

        // ======================================================
        // apb registers
        apb_setup = psel && !penable;
        apb_access = psel && penable;
        apb_mapped = (paddr[7:0] == BSP_CTRL_OFS) || (paddr[7:0] == BSP_STAT_OFS);
        if (apb_setup) begin
            next_s.prdata = BSP_RDATA_RST;
            if (paddr[7:0] == BSP_CTRL_OFS) begin
                next_s.prdata[BSP_CTRL_ODD_BIT] = s.parity_odd;
            end else if (paddr[7:0] == BSP_STAT_OFS) begin
                next_s.prdata[7:0] = {s.wr_swap, s.wr_phase, s.rd_phase,
                                      s.pb_err_n, s.pa_err_n};
            end
        end
        if (apb_access && pwrite && paddr[7:0] == BSP_CTRL_OFS) begin
            next_s.parity_odd = pwdata[BSP_CTRL_ODD_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= BSP_STATE_RST;
        end else begin
            s <= next_s;
        end
    end

    // ==========================================================
    // outputs
    assign prdata = s.prdata;
    assign pready = 1'b1;
    assign pslverr = apb_access && !apb_mapped;
    assign a_dout = s.a_dout;
    assign b_dout = s.b_dout;
    assign port_a_parity_err_n = s.pa_err_n;
    assign port_b_parity_err_n = s.pb_err_n;
    assign a_wr_data = s.a_wr_data;
    assign a_to_b_queue_push = s.ab_q_push;
    assign a_to_b_mailbox_wr = s.ab_mb_wr;
    assign b_wr_data = s.b_wr_data;
    assign b_to_a_queue_push = s.ba_q_push;
    assign b_to_a_mailbox_wr = s.ba_mb_wr;
    assign a_to_b_queue_pop = b_new_rd;
    assign b_to_a_queue_pop = a_rd && !a_ctl.port_a_mailbox_sel;

endmodule // bsp_unit

`default_nettype wire

// File: bench/bsp_unit_props.sv
// checker: port-level properties of the byte swap and parity unit
`timescale 1ns/1ns
`default_nettype none
module bsp_unit_props
    import bsp_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock, reset, apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    // port a
    input wire bsp_a_ctl_t a_ctl,
    input wire logic [35:0] a_din,
    input wire logic [35:0] a_dout,
    input wire logic port_a_parity_err_n,
    // port b
    input wire bsp_b_ctl_t b_ctl,
    input wire logic [35:0] b_din,
    input wire logic [35:0] b_dout,
    input wire logic port_b_parity_err_n,
    // storage side
    input wire logic [35:0] a_wr_data,
    input wire logic a_to_b_queue_push,
    input wire logic a_to_b_queue_pop,
    input wire logic [35:0] a_to_b_queue_rd_data,
    input wire logic [35:0] a_to_b_mailbox_data,
    input wire logic [35:0] b_to_a_mailbox_data
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic odd;
    logic a_rd, a_hold, b_rd, b_hold;
    logic [1:0] wd;
    logic [3:0] bmask;
    function automatic logic [3:0] bad(input logic [35:0] w, input logic o);
        for (int i = 0; i < 4; i++) bad[i] = ^w[i*9+:9] ^ o;
    endfunction
    function automatic logic [35:0] gen(input logic [35:0] w, input logic o);
        for (int i = 0; i < 4; i++) w[i*9+8] = ^w[i*9+:8] ^ o;
        return w;
    endfunction
    function automatic logic [35:0] swp(input logic [35:0] w, input logic [1:0] m);
        case (m)
            2'b01: return {w[8:0], w[17:9], w[26:18], w[35:27]};
            2'b10: return {w[17:0], w[35:18]};
            2'b11: return {w[26:18], w[35:27], w[8:0], w[17:9]};
            default: return w;
        endcase
    endfunction
    // shadow of the parity sense register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) odd <= BSP_ODD_RST;
        else if (psel && penable && pwrite && paddr == '0) odd <= pwdata[0];
    end
    assign wd = {b_ctl.b_width_sel_hi, b_ctl.b_width_sel_lo};
    assign a_rd = !a_ctl.port_a_select_n && a_ctl.port_a_xfer_gate && !a_ctl.port_a_write_not_read;
    assign a_hold = a_rd && a_ctl.port_a_mailbox_sel && a_ctl.port_a_parity_gen_sel;
    assign b_rd = !b_ctl.port_b_select_n && b_ctl.port_b_xfer_gate && !b_ctl.port_b_write_not_read;
    assign b_hold = b_rd && wd == 2'b11 && b_ctl.port_b_parity_gen_sel;
    always_comb begin
        case (wd)
            2'b01: bmask = b_ctl.big_endian_sel_n ? 4'h3 : 4'hc;
            2'b10: bmask = b_ctl.big_endian_sel_n ? 4'h2 : 4'h8;
            default: bmask = 4'hf;
        endcase
    end
    // ==========
    // properties
    property p_a_err; !a_hold |=> port_a_parity_err_n == !(|bad($past(a_din), $past(odd))); endproperty
    a_a_err: assert property (p_a_err) else $error("port a flag wrong");
    property p_b_err;
        !b_hold |=> port_b_parity_err_n == !(|($past(bmask) & bad($past(b_din), $past(odd))));
    endproperty
    a_b_err: assert property (p_b_err) else $error("port b flag wrong");
    property p_a_hold; a_hold |=> port_a_parity_err_n; endproperty
    a_a_hold: assert property (p_a_hold) else $error("port a flag not held");
    property p_b_hold; b_hold |=> port_b_parity_err_n; endproperty
    a_b_hold: assert property (p_b_hold) else $error("port b flag not held");
    property p_b_long;
        b_rd && wd == 2'b00 && !b_ctl.port_b_parity_gen_sel |-> a_to_b_queue_pop
            ##1 b_dout == swp($past(a_to_b_queue_rd_data), $past({b_ctl.swap_sel_hi, b_ctl.swap_sel_lo}));
    endproperty
    a_b_long: assert property (p_b_long) else $error("long read order wrong");
    property p_b_mail;
        b_rd && wd == 2'b11 && !b_ctl.port_b_parity_gen_sel |=> b_dout == $past(a_to_b_mailbox_data);
    endproperty
    a_b_mail: assert property (p_b_mail) else $error("mailbox read altered");
    property p_a_mgen; a_hold |=> a_dout == gen($past(b_to_a_mailbox_data), $past(odd)); endproperty
    a_a_mgen: assert property (p_a_mgen) else $error("mailbox parity wrong");
    property p_a_wr;
        !a_ctl.port_a_select_n && a_ctl.port_a_xfer_gate && a_ctl.port_a_write_not_read
            && !a_ctl.port_a_mailbox_sel |=> a_to_b_queue_push && a_wr_data == $past(a_din);
    endproperty
    a_a_wr: assert property (p_a_wr) else $error("queue write altered");
endmodule // bsp_unit_props
bind bsp_unit bsp_unit_props #(.ADDR_W(ADDR_W)) u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .a_ctl(a_ctl), .a_din(a_din), .a_dout(a_dout), .port_a_parity_err_n(port_a_parity_err_n),
    .b_ctl(b_ctl), .b_din(b_din), .b_dout(b_dout), .port_b_parity_err_n(port_b_parity_err_n),
    .a_wr_data(a_wr_data), .a_to_b_queue_push(a_to_b_queue_push),
    .a_to_b_queue_pop(a_to_b_queue_pop), .a_to_b_queue_rd_data(a_to_b_queue_rd_data),
    .a_to_b_mailbox_data(a_to_b_mailbox_data), .b_to_a_mailbox_data(b_to_a_mailbox_data));
`default_nettype wire

// File: bench/bsp_store.sv
// partner: queue and mailbox storage behind the unit
`timescale 1ns/1ns
`default_nettype none
module bsp_store (
    // clock
    input wire logic pclk,
    // a_to_b side
    input wire logic [35:0] a_wr_data,
    input wire logic a_to_b_queue_push,
    input wire logic a_to_b_mailbox_wr,
    input wire logic a_to_b_queue_pop,
    output logic [35:0] a_to_b_queue_rd_data,
    output logic [35:0] a_to_b_mailbox_data,
    // b_to_a side
    input wire logic [35:0] b_wr_data,
    input wire logic b_to_a_queue_push,
    input wire logic b_to_a_mailbox_wr,
    input wire logic b_to_a_queue_pop,
    output logic [35:0] b_to_a_queue_rd_data,
    output logic [35:0] b_to_a_mailbox_data
);
    logic [35:0] ma [8] = '{default: '0};
    logic [35:0] mb [8] = '{default: '0};
    logic [35:0] xa = '0;
    logic [35:0] xb = '0;
    logic [2:0] wa = '0, ra = '0, wb = '0, rb = '0;
    always_ff @(posedge pclk) begin
        if (a_to_b_queue_push) ma[wa] <= a_wr_data;
        if (a_to_b_queue_push) wa <= wa + 3'h1;
        if (a_to_b_queue_pop && wa != ra) ra <= ra + 3'h1;
        if (b_to_a_queue_push) mb[wb] <= b_wr_data;
        if (b_to_a_queue_push) wb <= wb + 3'h1;
        if (b_to_a_queue_pop && wb != rb) rb <= rb + 3'h1;
        if (a_to_b_mailbox_wr) xa <= a_wr_data;
        if (b_to_a_mailbox_wr) xb <= b_wr_data;
    end
    // empty head shows the inverse of the last word
    assign a_to_b_queue_rd_data = wa != ra ? ma[ra] : ~ma[ra-3'h1];
    assign b_to_a_queue_rd_data = wb != rb ? mb[rb] : ~mb[rb-3'h1];
    assign a_to_b_mailbox_data = xa;
    assign b_to_a_mailbox_data = xb;
endmodule // bsp_store
`default_nettype wire

// File: bench/tb_top.sv
// testbench: directed tests of the byte swap and parity unit
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import bsp_pkg::*;
    localparam logic [35:0] W = 36'h1_2345_6789;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, pa_err_n, pb_err_n, aq_push, am_wr, aq_pop, bq_push, bm_wr, bq_pop;
    bsp_a_ctl_t a_ctl = 5'h10;
    bsp_b_ctl_t b_ctl = 9'h100;
    logic [35:0] a_din = 36'h8_0402_0100, b_din = 36'h8_0402_0100;
    logic [35:0] a_dout, b_dout, a_wd, b_wd, aq_rd, am_rd, bq_rd, bm_rd;
    logic [39:0] pc [4] = '{{3'b010, 36'h1, 1'b1}, {3'b011, 36'h1, 1'b0},
        {3'b101, 36'h1, 1'b1}, {3'b101, 36'h200, 1'b0}};
    int miscompares = 0, n_checks = 0;
    bsp_unit dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .a_ctl(a_ctl), .a_din(a_din), .a_dout(a_dout),
        .port_a_parity_err_n(pa_err_n), .b_ctl(b_ctl), .b_din(b_din), .b_dout(b_dout),
        .port_b_parity_err_n(pb_err_n), .a_wr_data(a_wd), .a_to_b_queue_push(aq_push),
        .a_to_b_mailbox_wr(am_wr), .a_to_b_queue_rd_data(aq_rd), .a_to_b_queue_pop(aq_pop),
        .a_to_b_mailbox_data(am_rd), .b_wr_data(b_wd), .b_to_a_queue_push(bq_push),
        .b_to_a_mailbox_wr(bm_wr), .b_to_a_queue_rd_data(bq_rd), .b_to_a_queue_pop(bq_pop),
        .b_to_a_mailbox_data(bm_rd));
    bsp_store u_store (.pclk(pclk), .a_wr_data(a_wd), .a_to_b_queue_push(aq_push),
        .a_to_b_mailbox_wr(am_wr), .a_to_b_queue_pop(aq_pop), .a_to_b_queue_rd_data(aq_rd),
        .a_to_b_mailbox_data(am_rd), .b_wr_data(b_wd), .b_to_a_queue_push(bq_push),
        .b_to_a_mailbox_wr(bm_wr), .b_to_a_queue_pop(bq_pop), .b_to_a_queue_rd_data(bq_rd),
        .b_to_a_mailbox_data(bm_rd));
    always #4 pclk = ~pclk;
    // ==========
    // helpers
    function automatic logic [35:0] gen(input logic [35:0] w, input logic o);
        for (int i = 0; i < 4; i++) w[i*9+8] = ^w[i*9+:8] ^ o;
        return w;
    endfunction
    function automatic logic [35:0] swp(input logic [35:0] w, input logic [1:0] m);
        case (m)
            2'b01: return {w[8:0], w[17:9], w[26:18], w[35:27]};
            2'b10: return {w[17:0], w[35:18]};
            2'b11: return {w[26:18], w[35:27], w[8:0], w[17:9]};
            default: return w;
        endcase
    endfunction
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic pa(input logic w, input logic mb, input logic g, input logic [35:0] d);
        @(posedge pclk);
        a_ctl <= {1'b0, 1'b1, w, mb, g};
        a_din <= d;
        @(posedge pclk);
        a_ctl.port_a_xfer_gate <= 1'b0;
        #1;
    endtask
    task automatic pb(input logic w, input logic [1:0] wd, input logic bn, input logic [1:0] sw,
            input logic g, input logic [35:0] d);
        @(posedge pclk);
        b_ctl <= {1'b0, 1'b1, w, wd, bn, sw, g};
        b_din <= d;
        @(posedge pclk);
        b_ctl.port_b_xfer_gate <= 1'b0;
        #1;
    endtask
    // ==========
    // tests
    initial begin
        logic [31:0] r;
        logic e;
        logic [35:0] w;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, BSP_CTRL_OFS, 32'h0, r, e);
        chk(r[0], BSP_ODD_RST);
        apb(1'b0, 8'h08, 32'h0, r, e);
        chk({e, r}, 33'h1_0000_0000);
        apb(1'b1, BSP_CTRL_OFS, 32'h0, r, e);
        apb(1'b0, BSP_CTRL_OFS, 32'h0, r, e);
        chk({e, r}, 33'h0);
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            {b_ctl.b_width_sel_hi, b_ctl.b_width_sel_lo, b_ctl.big_endian_sel_n, b_din} <= pc[i][39:1];
            a_din <= 36'h1;
            repeat (2) @(posedge pclk);
            #1;
            chk(pb_err_n, pc[i][0]);
        end
        chk(pa_err_n, 1'b0);
        for (int k = 0; k < 5; k++) pa(1'b1, 1'b0, 1'b0, W + 36'(k));
        for (int m = 0; m < 4; m++) begin
            pb(1'b0, 2'b00, 1'b1, 2'(m), 1'b0, 36'h0);
            chk(b_dout, swp(W + 36'(m), 2'(m)));
        end
        w = swp(W + 36'h4, 2'b01);
        for (int j = 0; j < 4; j++) begin
            pb(1'b0, 2'b10, 1'b0, 2'(j + 1), 1'b0, 36'h0);
            chk(b_dout[35:27], w[35-9*j -: 9]);
        end
        pb(1'b1, 2'b01, 1'b0, 2'b10, 1'b0, {W[35:18], 18'h0});
        pb(1'b1, 2'b01, 1'b0, 2'b11, 1'b0, {W[17:0], 18'h0});
        pa(1'b0, 1'b0, 1'b0, 36'h0);
        chk(a_dout, swp(W, 2'b10));
        pa(1'b1, 1'b1, 1'b0, W);
        pb(1'b0, 2'b11, 1'b1, 2'b01, 1'b0, 36'h0);
        chk(b_dout, W);
        pb(1'b0, 2'b11, 1'b1, 2'b01, 1'b1, 36'h1);
        chk(b_dout, gen(W, 1'b0));
        chk(pb_err_n, 1'b1);
        pb(1'b1, 2'b11, 1'b1, 2'b00, 1'b0, W + 36'h1);
        pa(1'b0, 1'b1, 1'b1, 36'h1);
        chk(a_dout, gen(W + 36'h1, 1'b0));
        chk(pa_err_n, 1'b1);
        pa(1'b1, 1'b0, 1'b0, W);
        w = gen(W, 1'b0);
        for (int j = 0; j < 2; j++) begin
            pb(1'b0, 2'b01, 1'b1, 2'b00, 1'(j == 0), 36'h0);
            chk(b_dout[17:0], w[18*j +: 18]);
        end
        for (int j = 0; j < 4; j++) pb(1'b1, 2'b10, 1'b1, 2'(j + 1), 1'b0, {27'h0, W[9*j +: 9]});
        pa(1'b0, 1'b0, 1'b1, 36'h0);
        chk(a_dout, gen(swp(W, 2'b01), 1'b0));
        report_and_stop();
    end
    initial begin
        repeat (2000) @(posedge pclk);
        miscompares++;
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
